// ---- fpu_err_pkg.sv ----
package fpu_err_pkg;

    // Clock period
    localparam int CLK_PERIOD_NS = 20;

    // Least length of the short error pulse of a no-wait instruction
    localparam int NW_PULSE_NS     = 40;
    localparam int NW_PULSE_CYCLES = (NW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Longest length of the interrupt sampling window
    localparam int WINDOW_NS     = 100;
    localparam int WINDOW_CYCLES = WINDOW_NS / CLK_PERIOD_NS;

    // Width of the cycle counter
    localparam int CNT_W = 4;

    // Pin synchroniser reset levels: interrupt pin idle low, ignore pin idle high
    localparam logic [1:0] SYNC_RESET_VAL = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_PULSE  = 2'b01,
        ST_WINDOW = 2'b10,
        ST_EXEC   = 2'b11
    } instr_state_t;

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int              WIDTH     = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out
);

    ////////////////////////////////////////////////////////////////////////
    // Two flip-flops per bit
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic meta_r;
            logic sync_r;
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_r <= RESET_VAL[g];
                    sync_r <= RESET_VAL[g];
                end else begin
                    meta_r <= pin_in[g];
                    sync_r <= meta_r;
                end
            end
            assign pin_sync_out[g] = sync_r;
        end
    endgenerate

endmodule

`default_nettype wire

// ---- fpu_error_irq_glue.sv ----
// Notes on behaviour
// - Unmasked exception in compatibility mode drives error output, requests interrupt
// - Ignore must be off by handler exit
// - Ignore active: instructions run unblocked
// - Clearing exception deasserts error output
// - No-wait instruction in compatibility mode pulses error, then proceeds
// - Every instruction opens an interrupt sampling window, except one blocked by a pending exception
// - No-wait window opens after its error pulse
// - Late interrupt taken at next instruction boundary
// - Deferred exception asserts error at next instruction in compatibility mode
// - After clear, no-wait never asserts error
// - Compatibility mode with ignore: disregard, keep quiet
`timescale 1ns/10ps
`default_nettype none

module fpu_error_irq_glue #(
    parameter int NW_PULSE_CYCLES = fpu_err_pkg::NW_PULSE_CYCLES,
    parameter int WINDOW_CYCLES   = fpu_err_pkg::WINDOW_CYCLES
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic native_error_mode_bit,
    input  wire logic exc_detect,
    input  wire logic exc_deferred,
    input  wire logic exc_clear,
    input  wire logic instr_start,
    input  wire logic instr_no_wait,
    input  wire logic instr_boundary,
    input  wire logic handler_exit,
    input  wire logic ignore_numeric_error_n,
    input  wire logic cpu_interrupt_in,
    output logic      fp_error_out_n,
    output logic      instr_blocked,
    output logic      irq_window,
    output logic      irq_take_window,
    output logic      irq_take_boundary,
    output logic      native_trap,
    output logic      ignore_left_active
);

    localparam int CW = fpu_err_pkg::CNT_W;

    generate
        if (NW_PULSE_CYCLES < 1 || NW_PULSE_CYCLES > (1 << CW)) begin : g_bad_pulse
            $error("NW_PULSE_CYCLES out of range");
        end
        if (WINDOW_CYCLES < 1 || WINDOW_CYCLES > (1 << CW)) begin : g_bad_window
            $error("WINDOW_CYCLES out of range");
        end
    endgenerate

    localparam logic [CW-1:0] PULSE_LOAD = CW'(NW_PULSE_CYCLES - 1);
    localparam logic [CW-1:0] WIN_LOAD   = CW'(WINDOW_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] pins_s;
    logic       ign_n_s;
    logic       int_s;

    pin_sync #(
        .WIDTH     (2),
        .RESET_VAL (fpu_err_pkg::SYNC_RESET_VAL)
    ) u_pin_sync (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .pin_in       ({ignore_numeric_error_n, cpu_interrupt_in}),
        .pin_sync_out (pins_s)
    );

    assign ign_n_s = pins_s[1];
    assign int_s   = pins_s[0];

    logic ignore_act;
    logic compat;
    assign ignore_act = ~ign_n_s;
    assign compat     = ~native_error_mode_bit;

    ////////////////////////////////////////////////////////////////////////
    // State
    fpu_err_pkg::instr_state_t state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic pending_r, pending_nxt;
    logic deferred_r, deferred_nxt;
    logic err_lvl_r, err_lvl_nxt;
    logic late_r, late_nxt;
    logic err_n_r, err_n_nxt;
    logic blocked_r, blocked_nxt;
    logic win_r, win_nxt;
    logic take_w_r, take_w_nxt;
    logic take_b_r, take_b_nxt;
    logic trap_r, trap_nxt;
    logic misuse_r, misuse_nxt;

    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        pending_nxt  = pending_r;
        deferred_nxt = deferred_r;
        err_lvl_nxt  = err_lvl_r;
        late_nxt     = late_r;
        blocked_nxt  = blocked_r;
        take_w_nxt   = 1'b0;
        take_b_nxt   = 1'b0;
        trap_nxt     = 1'b0;
        misuse_nxt   = misuse_r;

        // Clearing the exception drops the error level
        if (exc_clear) begin
            pending_nxt = 1'b0;
            err_lvl_nxt = 1'b0;
            blocked_nxt = 1'b0;
        end
        // A new exception wins over a clear in the same cycle
        if (exc_detect) begin
            pending_nxt  = 1'b1;
            deferred_nxt = exc_deferred;
            if (compat && !exc_deferred && !ignore_act) begin
                err_lvl_nxt = 1'b1;
            end
            if (!compat && !exc_deferred) begin
                trap_nxt = 1'b1;
            end
        end
        // Immediate exception reported once ignore is released
        if (compat && pending_r && !deferred_r && !ignore_act && !exc_clear) begin
            err_lvl_nxt = 1'b1;
        end

        unique case (state_r)
            fpu_err_pkg::ST_IDLE: begin
                if (instr_start) begin
                    state_nxt = fpu_err_pkg::ST_WINDOW;
                    cnt_nxt   = WIN_LOAD;
                    if (pending_r && !exc_clear) begin
                        if (!compat) begin
                            trap_nxt = !instr_no_wait;
                        end else if (ignore_act) begin
                            blocked_nxt = 1'b0;
                        end else if (instr_no_wait) begin
                            state_nxt = fpu_err_pkg::ST_PULSE;
                            cnt_nxt   = PULSE_LOAD;
                        end else begin
                            err_lvl_nxt = 1'b1;
                            blocked_nxt = 1'b1;
                            state_nxt   = fpu_err_pkg::ST_EXEC;
                        end
                    end
                end
            end
            fpu_err_pkg::ST_PULSE: begin
                if (cnt_r == '0) begin
                    state_nxt = fpu_err_pkg::ST_WINDOW;
                    cnt_nxt   = WIN_LOAD;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            fpu_err_pkg::ST_WINDOW: begin
                if (int_s) begin
                    take_w_nxt = 1'b1;
                    state_nxt  = fpu_err_pkg::ST_EXEC;
                end else if (cnt_r == '0) begin
                    state_nxt = fpu_err_pkg::ST_EXEC;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            fpu_err_pkg::ST_EXEC: begin
                if (blocked_r && int_s && !exc_clear) begin
                    take_w_nxt  = 1'b1;
                    blocked_nxt = 1'b0;
                end else if (instr_boundary && !blocked_r) begin
                    state_nxt = fpu_err_pkg::ST_IDLE;
                end
            end
        endcase

        // Interrupt outside any window, with no instruction blocked, waits for the boundary
        if (int_s && state_r != fpu_err_pkg::ST_WINDOW && !blocked_r) begin
            late_nxt = 1'b1;
        end
        if (instr_boundary && late_r) begin
            take_b_nxt = 1'b1;
            late_nxt   = 1'b0;
        end

        if (handler_exit && ignore_act) begin
            misuse_nxt = 1'b1;
        end
    end

    assign err_n_nxt = ~(compat && (err_lvl_nxt || state_nxt == fpu_err_pkg::ST_PULSE));
    assign win_nxt   = (state_nxt == fpu_err_pkg::ST_WINDOW);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r    <= fpu_err_pkg::ST_IDLE;
            cnt_r      <= '0;
            pending_r  <= 1'b0;
            deferred_r <= 1'b0;
            err_lvl_r  <= 1'b0;
            late_r     <= 1'b0;
            err_n_r    <= 1'b1;
            blocked_r  <= 1'b0;
            win_r      <= 1'b0;
            take_w_r   <= 1'b0;
            take_b_r   <= 1'b0;
            trap_r     <= 1'b0;
            misuse_r   <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            pending_r  <= pending_nxt;
            deferred_r <= deferred_nxt;
            err_lvl_r  <= err_lvl_nxt;
            late_r     <= late_nxt;
            err_n_r    <= err_n_nxt;
            blocked_r  <= blocked_nxt;
            win_r      <= win_nxt;
            take_w_r   <= take_w_nxt;
            take_b_r   <= take_b_nxt;
            trap_r     <= trap_nxt;
            misuse_r   <= misuse_nxt;
        end
    end

    assign fp_error_out_n     = err_n_r;
    assign instr_blocked      = blocked_r;
    assign irq_window         = win_r;
    assign irq_take_window    = take_w_r;
    assign irq_take_boundary  = take_b_r;
    assign native_trap        = trap_r;
    assign ignore_left_active = misuse_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_err_immediate;
        @(posedge clk) disable iff (sys_rst)
        compat && exc_detect && !exc_deferred && !ignore_act
            |=> !fp_error_out_n ##1 (!fp_error_out_n || $past(exc_clear) || $past(native_error_mode_bit));
    endproperty
    a_err_immediate: assert property (p_err_immediate) else $error("immediate exception not reported");

    property p_err_clear;
        @(posedge clk) disable iff (sys_rst)
        exc_clear && !exc_detect && state_r != fpu_err_pkg::ST_PULSE && state_nxt != fpu_err_pkg::ST_PULSE
            |=> fp_error_out_n;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error output stayed after clear");

    property p_nw_pulse;
        @(posedge clk) disable iff (sys_rst)
        state_r == fpu_err_pkg::ST_IDLE && instr_start && instr_no_wait && pending_r && compat
            && !ignore_act && !exc_clear |=> state_r == fpu_err_pkg::ST_PULSE && !fp_error_out_n;
    endproperty
    a_nw_pulse: assert property (p_nw_pulse) else $error("no-wait pulse missing");

    property p_window_after_pulse;
        @(posedge clk) disable iff (sys_rst)
        state_r == fpu_err_pkg::ST_PULSE && cnt_r == '0 |=> irq_window && !$past(irq_window);
    endproperty
    a_window_after_pulse: assert property (p_window_after_pulse) else $error("window not after pulse");

    property p_take_in_window;
        @(posedge clk) disable iff (sys_rst)
        irq_window && int_s |=> irq_take_window ##1 !irq_take_window;
    endproperty
    a_take_in_window: assert property (p_take_in_window) else $error("interrupt in window not taken");

    property p_late_boundary;
        @(posedge clk) disable iff (sys_rst)
        late_r && instr_boundary |=> irq_take_boundary && !late_r;
    endproperty
    a_late_boundary: assert property (p_late_boundary) else $error("late interrupt not taken at boundary");

    property p_deferred_quiet;
        @(posedge clk) disable iff (sys_rst)
        exc_detect && exc_deferred && fp_error_out_n && !err_lvl_r && state_r == fpu_err_pkg::ST_IDLE
            && !instr_start && !pending_r |=> fp_error_out_n;
    endproperty
    a_deferred_quiet: assert property (p_deferred_quiet) else $error("deferred exception reported early");

    property p_quiet_after_clear;
        @(posedge clk) disable iff (sys_rst)
        !pending_r && !err_lvl_r && state_r == fpu_err_pkg::ST_IDLE && !exc_detect |=> fp_error_out_n;
    endproperty
    a_quiet_after_clear: assert property (p_quiet_after_clear) else $error("error asserted with nothing pending");

    property p_ignore_unblocked;
        @(posedge clk) disable iff (sys_rst)
        compat && ignore_act && state_r == fpu_err_pkg::ST_IDLE && instr_start |=> !instr_blocked;
    endproperty
    a_ignore_unblocked: assert property (p_ignore_unblocked) else $error("blocked while ignore active");

    property p_ignore_no_err;
        @(posedge clk) disable iff (sys_rst)
        ignore_act && fp_error_out_n && state_r != fpu_err_pkg::ST_PULSE |=> fp_error_out_n;
    endproperty
    a_ignore_no_err: assert property (p_ignore_no_err) else $error("error raised while ignore active");

    property p_exit_flag;
        @(posedge clk) disable iff (sys_rst)
        handler_exit && ignore_act |=> ignore_left_active [*2];
    endproperty
    a_exit_flag: assert property (p_exit_flag) else $error("ignore left active not flagged");

    c_nw_pulse: cover property (@(posedge clk) disable iff (sys_rst)
        state_r == fpu_err_pkg::ST_PULSE ##1 irq_window ##[1:8] irq_take_window);
    c_blocked: cover property (@(posedge clk) disable iff (sys_rst) instr_blocked ##[1:20] !instr_blocked);
    c_boundary: cover property (@(posedge clk) disable iff (sys_rst) irq_take_boundary);

endmodule

`default_nettype wire

// ---- fpu_glue_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// Request latch, ignore flip-flop and delayed controller path
module fpu_glue_partner (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       fp_error_out_n,
    input  wire logic       port_access,
    input  wire logic       force_ignore,
    input  wire logic [3:0] irq_delay,
    output logic            ignore_numeric_error_n,
    output logic            pic_request_line_thirteen,
    output logic            cpu_interrupt_in
);
    logic        req_r;
    logic        req_nxt;
    logic        ign_r;
    logic        ign_nxt;
    logic        err_prev_r;
    logic [15:0] dly_r;
    logic [15:0] dly_nxt;
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        req_nxt = req_r;
        ign_nxt = ign_r;
        if (port_access) begin
            req_nxt = 1'b0;
        end else if (err_prev_r && !fp_error_out_n) begin
            req_nxt = 1'b1;
        end
        if (fp_error_out_n) begin
            ign_nxt = 1'b0;
        end else if (port_access) begin
            ign_nxt = 1'b1;
        end
        dly_nxt = {dly_r[14:0], req_r};
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_r      <= 1'b0;
            ign_r      <= 1'b0;
            err_prev_r <= 1'b1;
            dly_r      <= 16'h0000;
        end else begin
            req_r      <= req_nxt;
            ign_r      <= ign_nxt;
            err_prev_r <= fp_error_out_n;
            dly_r      <= dly_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    assign ignore_numeric_error_n    = ~((ign_r & ~fp_error_out_n) | force_ignore);
    assign pic_request_line_thirteen = req_r;
    assign cpu_interrupt_in          = dly_r[irq_delay];
endmodule
`default_nettype wire

// ---- fpu_error_irq_glue_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module fpu_error_irq_glue_tb;
    logic       clk;
    logic       sys_rst;
    logic [5:0] pv;
    logic       qual;
    logic       native_error_mode_bit;
    logic       force_ignore;
    logic [3:0] irq_delay;
    logic       fp_error_out_n;
    logic       instr_blocked;
    logic       irq_window;
    logic       irq_take_window;
    logic       irq_take_boundary;
    logic       native_trap;
    logic       ignore_left_active;
    logic       ignore_numeric_error_n;
    logic       cpu_interrupt_in;
    logic       pic_request_line_thirteen;
    int         err_count = 0;
    int         samples_checked = 0;
    int         win_cnt = 0;
    ////////////////////////////////////////////////////////////////////////
    fpu_error_irq_glue #(.NW_PULSE_CYCLES(2), .WINDOW_CYCLES(5)) u_fpu_error_irq_glue (
        .clk(clk), .sys_rst(sys_rst), .native_error_mode_bit(native_error_mode_bit),
        .exc_detect(pv[0]), .exc_deferred(qual), .exc_clear(pv[1]), .instr_start(pv[2]),
        .instr_no_wait(qual), .instr_boundary(pv[3]), .handler_exit(pv[4]),
        .ignore_numeric_error_n(ignore_numeric_error_n), .cpu_interrupt_in(cpu_interrupt_in),
        .fp_error_out_n(fp_error_out_n), .instr_blocked(instr_blocked), .irq_window(irq_window),
        .irq_take_window(irq_take_window), .irq_take_boundary(irq_take_boundary),
        .native_trap(native_trap), .ignore_left_active(ignore_left_active));
    fpu_glue_partner u_fpu_glue_partner (
        .clk(clk), .sys_rst(sys_rst), .fp_error_out_n(fp_error_out_n), .port_access(pv[5]),
        .force_ignore(force_ignore), .irq_delay(irq_delay),
        .ignore_numeric_error_n(ignore_numeric_error_n), .pic_request_line_thirteen(pic_request_line_thirteen),
        .cpu_interrupt_in(cpu_interrupt_in));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (irq_take_window === 1'b1) win_cnt <= win_cnt + 1;
    end
    function automatic logic err_level(input logic nat, input logic dfr);
        return nat | dfr;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int i, input logic q);
        @(posedge clk);
        pv[i] <= 1'b1;
        qual  <= q;
        @(posedge clk);
        pv[i] <= 1'b0;
        #1;
    endtask
    task automatic chk(input string what, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic settle;
        pulse(1, 1'b0);
        pulse(5, 1'b0);
        tick(18);
        pulse(3, 1'b0);
        tick(2);
    endtask
    task automatic wrap_up;
        if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int   n;
        logic nat;
        logic dfr;
        logic ok;
        pv = 6'h00; qual = 1'b0; native_error_mode_bit = 1'b0;
        force_ignore = 1'b0; irq_delay = 4'h0; sys_rst = 1'b1;
        void'($urandom(32'h9c8e));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        tick(1);
        chk("fp_error_out_n", fp_error_out_n, 1'b1);
        chk("ignore_left_active", ignore_left_active, 1'b0);
        for (int k = 0; k < 16; k++) begin
            nat = 1'($urandom_range(1));
            dfr = 1'($urandom_range(1));
            @(posedge clk);
            native_error_mode_bit <= nat;
            pulse(0, dfr);
            chk("fp_error_out_n", fp_error_out_n, err_level(nat, dfr));
            chk("native_trap", native_trap, nat & ~dfr);
            pulse(1, 1'b0);
            chk("fp_error_out_n", fp_error_out_n, 1'b1);
            settle();
        end
        @(posedge clk);
        native_error_mode_bit <= 1'b1;
        pulse(0, 1'b1);
        pulse(2, 1'b0);
        chk("native_trap", native_trap, 1'b1);
        chk("fp_error_out_n", fp_error_out_n, 1'b1);
        settle();
        @(posedge clk);
        native_error_mode_bit <= 1'b0;
        irq_delay <= 4'($urandom_range(3));
        pulse(0, 1'b1);
        chk("fp_error_out_n", fp_error_out_n, 1'b1);
        n = win_cnt;
        pulse(2, 1'b0);
        chk("fp_error_out_n", fp_error_out_n, 1'b0);
        chk("instr_blocked", instr_blocked, 1'b1);
        for (int t = 0; t < 20 && win_cnt == n; t++) tick(1);
        chk("irq_take_window", 1'(win_cnt != n), 1'b1);
        chk("instr_blocked", instr_blocked, 1'b0);
        settle();
        @(posedge clk);
        irq_delay <= 4'($urandom_range(2));
        pulse(0, 1'b1);
        n = win_cnt;
        pulse(2, 1'b1);
        chk("fp_error_out_n", fp_error_out_n, 1'b0);
        tick(1);
        chk("fp_error_out_n", fp_error_out_n, 1'b0);
        tick(1);
        chk("fp_error_out_n", fp_error_out_n, 1'b1);
        chk("irq_window", irq_window, 1'b1);
        for (int t = 0; t < 8 && win_cnt == n; t++) tick(1);
        chk("irq_take_window", 1'(win_cnt != n), 1'b1);
        settle();
        @(posedge clk);
        irq_delay <= 4'hc;
        pulse(0, 1'b1);
        n = win_cnt;
        pulse(2, 1'b1);
        tick(20);
        chk("irq_take_window", 1'(win_cnt != n), 1'b0);
        pulse(3, 1'b0);
        chk("irq_take_boundary", irq_take_boundary, 1'b1);
        settle();
        pulse(2, 1'b1);
        chk("fp_error_out_n", fp_error_out_n, 1'b1);
        ok = 1'b0;
        for (int t = 0; t < 6; t++) begin
            ok = ok | (irq_window === 1'b1);
            chk("fp_error_out_n", fp_error_out_n, 1'b1);
            tick(1);
        end
        chk("irq_window", ok, 1'b1);
        tick(4);
        pulse(3, 1'b0);
        @(posedge clk);
        force_ignore <= 1'b1;
        tick(3);
        pulse(0, 1'b0);
        tick(2);
        chk("fp_error_out_n", fp_error_out_n, 1'b1);
        pulse(2, 1'b0);
        chk("instr_blocked", instr_blocked, 1'b0);
        @(posedge clk);
        force_ignore <= 1'b0;
        settle();
        pulse(0, 1'b0);
        chk("fp_error_out_n", fp_error_out_n, 1'b0);
        tick(16);
        chk("pic_request_line_thirteen", pic_request_line_thirteen, 1'b1);
        pulse(5, 1'b0);
        chk("pic_request_line_thirteen", pic_request_line_thirteen, 1'b0);
        tick(4);
        pulse(2, 1'b0);
        chk("instr_blocked", instr_blocked, 1'b0);
        pulse(4, 1'b0);
        chk("ignore_left_active", ignore_left_active, 1'b1);
        pulse(1, 1'b0);
        tick(3);
        chk("ignore_numeric_error_n", ignore_numeric_error_n, 1'b1);
        chk("ignore_left_active", ignore_left_active, 1'b1);
        pulse(3, 1'b0);
        @(posedge clk);
        sys_rst <= 1'b1;
        tick(2);
        chk("ignore_left_active", ignore_left_active, 1'b0);
        @(posedge clk);
        sys_rst <= 1'b0;
        tick(2);
        chk("fp_error_out_n", fp_error_out_n, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
